// [core/wrcl_core.sv]
// Wiper setting, preload and control register logic with command execution.
// Assumes commands arrive as one-cycle strobes, already deframed, synchronous to sys_clk.
// Notes on behaviour
// - Control bit 0 low freezes wiper at stored value; high lets interface change it.
// - Control bit 1 low blocks nonvolatile programming; high (default) permits it.
// - Control bit 2 selects complementary (0, default) or split-rheostat mode (1).
// - Control bit 3 enables multi-byte write; stop or restart never clears it.
// - One preload register per wiper setting register holds a pending value.
// - Command 2 writes preloads; command 3 reads them back.
// - Load pin or command 6 transfers preloads to wiper registers, one or all.
// - Any new wiper setting value is copied into its preload register.
// - Split mode adds a second register pair by address bit 2; contents unchanged.
// - Strap high at power-up starts split mode, loading both strings from storage.
// - Effective mode is strap OR control bit 2.
// - Entering top or bottom end state leaves wiper registers unchanged.
// - End states exit by command 9 exit form, command 12 or any new wiper load.
// - Command 4 steps one position up or down, one or all.
// - Command 5 doubles or halves, one or all channels.
// - Doubling walks 0, 1, single bits to 1000 0000, then 1111 1111.
// - Halving shifts right filling zero down to 0000 0000.
// - Command 13 copies the low four data bits into control register.
// - Shared step code: data bit 0 one steps up (command 4) or doubles (command 5), zero steps down or halves.
module wrcl_core import wrcl_pkg::*; #(
  parameter int DATA_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [3:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic load_wiper_pin_n,
  input wire logic split_mode_strap_pin,
  input wire logic [DATA_W-1:0] nvm_lower_value,
  input wire logic [DATA_W-1:0] nvm_upper_value,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic [DATA_W-1:0] lower_wiper,
  output logic [DATA_W-1:0] upper_wiper,
  output logic split_mode,
  output logic top_end_state,
  output logic bottom_end_state,
  output logic nvm_program_allow,
  output logic multi_byte_write,
  output logic nvm_write_req,
  output logic [DATA_W-1:0] nvm_write_data,
  output logic nvm_write_upper
);
  localparam logic [DATA_W-1:0] FULL = {DATA_W{1'b1}};
  localparam logic [DATA_W-1:0] ZERO = '0;
  localparam logic [DATA_W-1:0] ONE = {{(DATA_W-1){1'b0}}, 1'b1};

  logic [3:0] ctrl_q;
  logic [DATA_W-1:0] wip_q [2];
  logic [DATA_W-1:0] pre_q [2];
  logic init_q;
  logic strap_q;
  logic ts_q;
  logic bs_q;
  logic load_pin_q;

  wire allow_w = ctrl_q[WRCL_BIT_WIPER_ALLOW];
  wire eff_split = strap_q | ctrl_q[WRCL_BIT_SPLIT];
  wire all_ch = cmd_addr[3]; // addr_bit_three selects all
  wire addr_bit_two = cmd_addr[2];
  wire go = cmd_valid & clk_en;
  wire pin_fall = load_pin_q & ~load_wiper_pin_n;
  // Pin transitions are ignored while a command executes, to avoid corruption.
  wire pin_load = pin_fall & ~go;
  wire is_wr = go & (cmd_code == WRCL_CMD_WR_WIPER);
  wire is_pre = go & (cmd_code == WRCL_CMD_WR_PRE);
  wire is_read = go & (cmd_code == WRCL_CMD_READ);
  wire is_lin = go & (cmd_code == WRCL_CMD_LIN);
  wire is_log = go & (cmd_code == WRCL_CMD_LOG);
  wire is_load = go & (cmd_code == WRCL_CMD_LOAD);
  wire is_nvrd = go & (cmd_code == WRCL_CMD_NVM_RD) & ~cmd_data[0];
  wire is_nvwr = go & (cmd_code == WRCL_CMD_NVM_RD) & cmd_data[0];
  wire is_scale = go & (cmd_code == WRCL_CMD_SCALE);
  wire is_shdn = go & (cmd_code == WRCL_CMD_SHDN);
  wire is_ctrl = go & (cmd_code == WRCL_CMD_CTRL);

  // Address bit 2 picks the upper register only in split mode; otherwise single commands go to lower
  wire [1:0] sel = all_ch ? 2'b11 : (addr_bit_two & eff_split ? 2'b10 : 2'b01);

  function automatic logic [DATA_W-1:0] step_lin(input logic [DATA_W-1:0] v,
                                                  input logic up);
    if (up) return (v == FULL) ? FULL : v + ONE;
    return (v == ZERO) ? ZERO : v - ONE;
  endfunction

  function automatic logic [DATA_W-1:0] step_log(input logic [DATA_W-1:0] v,
                                                  input logic up);
    if (up) begin
      if (v == ZERO) return ONE;
      if (v[DATA_W-1]) return FULL;
      return {v[DATA_W-2:0], 1'b0};
    end
    return {1'b0, v[DATA_W-1:1]};
  endfunction

  logic [DATA_W-1:0] wip_d [2];
  logic [DATA_W-1:0] pre_d [2];
  logic [1:0] wip_load;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      wip_d[i] = wip_q[i];
      pre_d[i] = pre_q[i];
      wip_load[i] = 1'b0;
      if (is_pre && sel[i]) begin
        pre_d[i] = cmd_data[DATA_W-1:0];
      end
      if (allow_w) begin
        if (is_wr && sel[i]) begin
          wip_d[i] = cmd_data[DATA_W-1:0];
          wip_load[i] = 1'b1;
        end else if ((is_load && sel[i]) || pin_load) begin
          wip_d[i] = pre_q[i];
          wip_load[i] = 1'b1;
        end else if (is_lin && sel[i]) begin
          wip_d[i] = step_lin(wip_q[i], cmd_data[0]);
          wip_load[i] = 1'b1;
        end else if (is_log && sel[i]) begin
          wip_d[i] = step_log(wip_q[i], cmd_data[0]);
          wip_load[i] = 1'b1;
        end
      end
      if (is_nvrd && sel[i]) begin
        // Recall from storage is the one wiper update allowed when frozen
        wip_d[i] = i == 0 ? nvm_lower_value : nvm_upper_value;
        wip_load[i] = 1'b1;
      end
      if (wip_load[i]) begin
        pre_d[i] = wip_d[i];
      end
    end
  end

  wire any_load = |wip_load | is_shdn;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= WRCL_CTRL_RESET;
      wip_q[0] <= ZERO;
      wip_q[1] <= ZERO;
      pre_q[0] <= ZERO;
      pre_q[1] <= ZERO;
      init_q <= 1'b1;
      strap_q <= 1'b0;
      load_pin_q <= 1'b1;
    end else if (clk_en) begin
      load_pin_q <= load_wiper_pin_n;
      if (init_q) begin
        // Strap and stored settings caught once, after reset release
        init_q <= 1'b0;
        strap_q <= split_mode_strap_pin;
        wip_q[0] <= nvm_lower_value;
        pre_q[0] <= nvm_lower_value;
        wip_q[1] <= nvm_upper_value;
        pre_q[1] <= nvm_upper_value;
      end else begin
        wip_q <= wip_d;
        pre_q <= pre_d;
        if (is_ctrl) begin
          ctrl_q <= cmd_data[3:0];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ts_q <= 1'b0;
      bs_q <= 1'b0;
    end else if (clk_en && !init_q) begin
      if (is_scale && cmd_data[7]) begin
        ts_q <= ~cmd_data[0];
        bs_q <= 1'b0;
      end else if (is_scale) begin
        bs_q <= cmd_data[0];
        ts_q <= 1'b0;
      end else if (any_load) begin
        ts_q <= 1'b0;
        bs_q <= 1'b0;
      end
    end
  end

  logic [DATA_W-1:0] rb_w;
  wire up_sel = addr_bit_two & eff_split;
  always_comb begin
    unique case (cmd_data[1:0])
      WRCL_RB_PRE: rb_w = pre_q[up_sel];
      WRCL_RB_NVM: rb_w = up_sel ? nvm_upper_value : nvm_lower_value;
      WRCL_RB_CTRL: rb_w = {{(DATA_W-4){1'b0}}, ctrl_q};
      WRCL_RB_WIPER: rb_w = wip_q[up_sel];
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= ZERO;
      rd_valid <= 1'b0;
      lower_wiper <= ZERO;
      upper_wiper <= ZERO;
      split_mode <= 1'b0;
      top_end_state <= 1'b0;
      bottom_end_state <= 1'b0;
      nvm_program_allow <= 1'b1;
      multi_byte_write <= 1'b0;
      nvm_write_req <= 1'b0;
      nvm_write_data <= ZERO;
      nvm_write_upper <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= is_read & ~init_q;
      if (is_read) begin
        rd_data <= rb_w;
      end
      lower_wiper <= wip_q[0];
      upper_wiper <= wip_q[1];
      split_mode <= eff_split;
      top_end_state <= ts_q;
      bottom_end_state <= bs_q;
      nvm_program_allow <= ctrl_q[WRCL_BIT_NVM_ALLOW];
      multi_byte_write <= ctrl_q[WRCL_BIT_MULTI];
      // Storage programming request only while programming is allowed
      nvm_write_req <= is_nvwr & ctrl_q[WRCL_BIT_NVM_ALLOW] & ~init_q;
      if (is_nvwr) begin
        nvm_write_data <= wip_q[up_sel];
        nvm_write_upper <= up_sel;
      end
    end
  end
endmodule

// [core/wrcl_pkg.sv]
// Package for the wiper register and command logic.
// Assumes a single 125 MHz clock domain and decoded serial commands.
package wrcl_pkg;
  localparam int WRCL_CTRL_W = 4;
  localparam logic [3:0] WRCL_CTRL_RESET = 4'h3;
  localparam int WRCL_BIT_WIPER_ALLOW = 0;
  localparam int WRCL_BIT_NVM_ALLOW = 1;
  localparam int WRCL_BIT_SPLIT = 2;
  localparam int WRCL_BIT_MULTI = 3;
  localparam logic [3:0] WRCL_CMD_NOP = 4'h0;
  localparam logic [3:0] WRCL_CMD_WR_WIPER = 4'h1;
  localparam logic [3:0] WRCL_CMD_WR_PRE = 4'h2;
  localparam logic [3:0] WRCL_CMD_READ = 4'h3;
  localparam logic [3:0] WRCL_CMD_LIN = 4'h4;
  localparam logic [3:0] WRCL_CMD_LOG = 4'h5;
  localparam logic [3:0] WRCL_CMD_LOAD = 4'h6;
  localparam logic [3:0] WRCL_CMD_NVM_RD = 4'h7;
  localparam logic [3:0] WRCL_CMD_SCALE = 4'h9;
  localparam logic [3:0] WRCL_CMD_SHDN = 4'hC;
  localparam logic [3:0] WRCL_CMD_CTRL = 4'hD;
  localparam logic [1:0] WRCL_RB_PRE = 2'h0;
  localparam logic [1:0] WRCL_RB_NVM = 2'h1;
  localparam logic [1:0] WRCL_RB_CTRL = 2'h2;
  localparam logic [1:0] WRCL_RB_WIPER = 2'h3;
endpackage

// [testbench/wrcl_core_props.sv]
// Port assertions for the wiper command block.
// Assumes commands come with idle cycles between them, as the host model sends.
module wrcl_core_props import wrcl_pkg::*; #(
  parameter int DATA_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [3:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic [DATA_W-1:0] lower_wiper,
  input wire logic rd_valid,
  input wire logic split_mode,
  input wire logic top_end_state,
  input wire logic bottom_end_state,
  input wire logic nvm_program_allow,
  input wire logic multi_byte_write,
  input wire logic nvm_write_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic go = cmd_valid && clk_en;
  wire logic ctl = go && cmd_code == WRCL_CMD_CTRL;
  wire logic lin = go && cmd_code == WRCL_CMD_LIN && !cmd_addr[2];
  multi_bit_a: assert property (ctl |-> ##2 multi_byte_write == $past(cmd_data[3], 2))
    else $error("multi byte bit not copied");
  nvm_allow_a: assert property (ctl |-> ##2 nvm_program_allow == $past(cmd_data[1], 2))
    else $error("program allow bit not copied");
  split_or_a: assert property (ctl && cmd_data[2] |-> ##2 split_mode)
    else $error("split mode not entered");
  nvm_gate_a: assert property (nvm_write_req |-> nvm_program_allow)
    else $error("store while programming blocked");
  step_top_a: assert property (lin && cmd_data[0] && lower_wiper == 8'hFF |-> ##2
    lower_wiper == 8'hFF) else $error("raise wrapped");
  step_zero_a: assert property (lin && !cmd_data[0] && lower_wiper == 8'h00 |-> ##2
    lower_wiper == 8'h00) else $error("lower wrapped");
  dbl_full_a: assert property (go && cmd_code == WRCL_CMD_LOG && cmd_data[0] &&
    !cmd_addr[2] && lower_wiper == 8'h80 |-> ##2 lower_wiper == 8'hFF) else $error("bad double");
  end_keep_a: assert property (go && cmd_code == WRCL_CMD_SCALE |=> $stable(lower_wiper)[*2])
    else $error("end state changed wiper");
  end_excl_a: assert property (!(top_end_state && bottom_end_state))
    else $error("both end states");
  rd_resp_a: assert property (go && cmd_code == WRCL_CMD_READ |-> ##[1:2] rd_valid)
    else $error("no read answer");
  cover property (go && cmd_code == WRCL_CMD_LOAD);
  cover property (top_end_state);
  cover property (rd_valid);
endmodule

bind wrcl_core wrcl_core_props #(.DATA_W(DATA_W)) u_props (.sys_clk(sys_clk), .rst(rst),
  .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
  .cmd_data(cmd_data), .lower_wiper(lower_wiper), .rd_valid(rd_valid),
  .split_mode(split_mode), .top_end_state(top_end_state),
  .bottom_end_state(bottom_end_state), .nvm_program_allow(nvm_program_allow),
  .multi_byte_write(multi_byte_write), .nvm_write_req(nvm_write_req));

// [testbench/wrcl_host.sv]
// Host model: sends one decoded command, then idles.
// Assumes the caller waits past reset and the init cycle.
module wrcl_host (
  input wire logic sys_clk,
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic [3:0] cmd_addr,
  output logic [7:0] cmd_data,
  output logic load_wiper_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 4'h0;
    cmd_addr = 4'h0;
    cmd_data = 8'h00;
    load_wiper_pin_n = 1'b1;
  end
  task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    // Released fields must not keep their old value
    cmd_code <= ~c;
    cmd_addr <= ~a;
    cmd_data <= ~d;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic pulse_load;
    @(posedge sys_clk);
    load_wiper_pin_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    load_wiper_pin_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule

// [testbench/wiper_register_command_logic_test.sv]
// Self-checking bench for the wiper command block.
// Assumes the host model and the bound checker.
module wiper_register_command_logic_test import wrcl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, cmd_valid, load_wiper_pin_n, rd_valid, split_mode, top_end_state;
  logic bottom_end_state, nvm_program_allow, multi_byte_write, nvm_write_req;
  logic [3:0] cmd_code, cmd_addr;
  logic [7:0] cmd_data, rd_data, lower_wiper, upper_wiper;
  logic ce = 1'b1;
  logic strap = 1'b0;
  int mismatches = 0;
  int n_checks = 0;
  // Rows: command nibble, data, expected lower wiper
  logic [19:0] rows [17] = '{20'h14040, 20'h21140, 20'h60011, 20'h40112, 20'h40011,
    20'h50008, 20'h50110, 20'h1FFFF, 20'h401FF, 20'h18080, 20'h501FF, 20'h5007F,
    20'h10000, 20'h40000, 20'h50101, 20'h70101, 20'h98001};
  wrcl_host host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .load_wiper_pin_n(load_wiper_pin_n));
  wrcl_core dut (.sys_clk(sys_clk), .rst(rst), .clk_en(ce), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .load_wiper_pin_n(load_wiper_pin_n), .split_mode_strap_pin(strap),
    .nvm_lower_value(8'h5A), .nvm_upper_value(8'hA5), .rd_data(rd_data), .rd_valid(rd_valid),
    .lower_wiper(lower_wiper), .upper_wiper(upper_wiper), .split_mode(split_mode),
    .top_end_state(top_end_state), .bottom_end_state(bottom_end_state),
    .nvm_program_allow(nvm_program_allow), .multi_byte_write(multi_byte_write),
    .nvm_write_req(nvm_write_req), .nvm_write_data(), .nvm_write_upper());
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("nvm_program_allow", 8'h01, {7'h0, nvm_program_allow});
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("lower_wiper", 8'h5A, lower_wiper);
    foreach (rows[i]) begin
      host.send(rows[i][19:16], 4'h0, rows[i][15:8]);
      chk("lower_wiper", rows[i][7:0], lower_wiper);
    end
    chk("top_end_state", 8'h01, {7'h0, top_end_state});
    host.send(WRCL_CMD_READ, 4'h0, 8'h00);
    chk("preload", 8'h01, rd_data);
    host.send(WRCL_CMD_WR_PRE, 4'h0, 8'h22);
    host.pulse_load();
    chk("lower_wiper", 8'h22, lower_wiper);
    chk("top_end_state", 8'h00, {7'h0, top_end_state});
    host.send(WRCL_CMD_CTRL, 4'h0, 8'h0D);
    chk("split_mode", 8'h01, {7'h0, split_mode});
    chk("multi_byte_write", 8'h01, {7'h0, multi_byte_write});
    chk("nvm_program_allow", 8'h00, {7'h0, nvm_program_allow});
    host.send(WRCL_CMD_WR_WIPER, 4'h4, 8'h77);
    chk("upper_wiper", 8'h77, upper_wiper);
    chk("lower_wiper", 8'h22, lower_wiper);
    host.send(WRCL_CMD_CTRL, 4'h0, 8'h0C);
    host.send(WRCL_CMD_WR_WIPER, 4'h0, 8'h33);
    chk("lower_wiper", 8'h22, lower_wiper);
    host.send(WRCL_CMD_READ, 4'h0, 8'h02);
    chk("control", 8'h0C, rd_data);
    host.send(WRCL_CMD_SCALE, 4'h0, 8'h01);
    chk("bottom_end_state", 8'h01, {7'h0, bottom_end_state});
    chk("lower_wiper", 8'h22, lower_wiper);
    host.send(WRCL_CMD_SCALE, 4'h0, 8'h00);
    chk("bottom_end_state", 8'h00, {7'h0, bottom_end_state});
    host.send(WRCL_CMD_CTRL, 4'h0, 8'h03);
    chk("split_mode", 8'h00, {7'h0, split_mode});
    // Clock enable low must freeze every register, commands included
    @(posedge sys_clk);
    ce <= 1'b0;
    host.send(WRCL_CMD_WR_WIPER, 4'h0, 8'h44);
    ce <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("lower_wiper", 8'h22, lower_wiper);
    // Mid-run reset with the strap high starts in split mode
    strap <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("split_mode", 8'h01, {7'h0, split_mode});
    chk("upper_wiper", 8'hA5, upper_wiper);
    chk("lower_wiper", 8'h5A, lower_wiper);
    print_verdict();
  end
endmodule
